// *** design/sfc_pkg.sv ***
package sfc_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS      = 20;
    localparam int RAMP_TICK_NS       = 10000;
    localparam int RAMP_TICK_CYC      = (RAMP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] RAMP_STEP = 16'h0010;

    // Parameter word addresses
    localparam logic [15:0] ADDR_GEAR3  = 16'h027A;
    localparam logic [15:0] ADDR_GEAR4  = 16'h027C;
    localparam logic [15:0] ADDR_RSVD_A = 16'h027E;
    localparam logic [15:0] ADDR_RSVD_B = 16'h0280;
    localparam logic [15:0] ADDR_SFW1   = 16'h0282;
    localparam logic [15:0] ADDR_SFW2   = 16'h0284;

    // Reset values
    localparam logic [31:0] GEAR3_RST = 32'h0000_0010;
    localparam logic [31:0] GEAR4_RST = 32'h0000_0010;
    localparam logic [15:0] SFW1_RST  = 16'h0000;
    localparam logic [15:0] SFW2_RST  = 16'h0000;

    // Gear numerator legal range
    localparam logic [31:0] GEAR_MIN = 32'h0000_0001;
    localparam logic [31:0] GEAR_MAX = 32'h03FF_FFFF;

    // Special function word one bit positions
    localparam int BIT_ABN_DIS  = 6;
    localparam int BIT_WIRE_ERR = 8;
    localparam int BIT_WIRE_CUT = 9;
    localparam int BIT_ZC_MODE  = 10;
    localparam int BIT_LIM_INH  = 11;
    localparam int BIT_PHL_DIS  = 12;
    localparam int BIT_ENC_DIS  = 13;

    // Numerator select codes
    localparam logic [1:0] SEL_DEFAULT = 2'h0;
    localparam logic [1:0] SEL_TWO     = 2'h1;
    localparam logic [1:0] SEL_THREE   = 2'h2;

    // Digital input pins
    typedef struct packed {
        logic zero_clamp_input;
        logic reverse_limit_input;
        logic forward_limit_input;
        logic numerator_select_high;
        logic numerator_select_low;
        logic pulse;
        logic dir_fwd;
    } sfc_din_t;

    // Fault detections
    typedef struct packed {
        logic abnormal_pulse;
        logic wiring_error;
        logic wiring_cutoff;
        logic phase_loss_fault;
        logic encoder_output_fault;
    } sfc_fault_t;

endpackage : sfc_pkg

// *** design/sfc_pin_sync.sv ***
`timescale 1ns/1ps
module sfc_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    // Pins
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;
    logic [W-1:0] out_next;

    // Bits only move once stage two and three agree, filtering one-cycle glitches
    always_comb begin
        for (int i = 0; i < W; i++) begin
            out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            out_reg <= '0;
        end else begin
            s1_reg  <= pin_in;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign sync_out = out_reg;

endmodule : sfc_pin_sync

// *** design/sfc_speed_ramp.sv ***
`timescale 1ns/1ps
module sfc_speed_ramp import sfc_pkg::*; (
    // Clock and reset
    input  wire logic               clk_in,
    input  wire logic               srst_in,
    // Control
    input  wire logic               tick_in,
    input  wire logic               force_in,
    input  wire logic signed [15:0] target_in,
    // Result
    output logic signed      [15:0] speed_out
);
    logic signed [15:0] cur_reg;
    logic signed [15:0] cur_next;
    logic signed [16:0] diff;
    logic signed [16:0] step;

    always_comb begin
        step = signed'({1'b0, RAMP_STEP});
        diff = 17'(target_in) - 17'(cur_reg);
        cur_next = cur_reg;
        if (force_in) begin
            cur_next = target_in;
        end else if (tick_in) begin
            if (diff > step) begin
                cur_next = cur_reg + signed'(RAMP_STEP);
            end else if (diff < -step) begin
                cur_next = cur_reg - signed'(RAMP_STEP);
            end else begin
                cur_next = target_in;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign speed_out = cur_reg;

endmodule : sfc_speed_ramp

// *** design/sfc_special_function.sv ***
// Notes on behaviour
// [RULE_01] Numerator select inputs pick gear numerator
// [RULE_02] Software writes zero to bits 2..5
// [RULE_03] Bit 6 set disables abnormal pulse detection
// [RULE_04] Bit 8 set enables wiring error detection
// [RULE_05] Bit 9 set enables wiring cut-off detection
// [RULE_06] Clamp needs speed mode, input, low command
// [RULE_07] Bit 10 clear: lock position while clamped
// [RULE_08] Bit 10 set, analog: ramp to zero
// [RULE_09] Bit 10 set, internal: force zero at once
// [RULE_10] Bit 11 clear: accept pulses despite limits
// [RULE_11] Bit 11 set: block pulses toward limit
// [RULE_12] Both limits with inhibit block all pulses
// [RULE_13] Bit 12 set disables phase loss detection
// [RULE_14] Bit 13 set disables encoder output detection
// [RULE_15] Software writes zero to bits 14, 15
`timescale 1ns/1ps
module sfc_special_function import sfc_pkg::*; (
    // Clock and reset
    input  wire logic               clk_in,
    input  wire logic               srst_in,
    // Parameter access port
    input  wire logic        [15:0] par_addr_in,
    input  wire logic        [31:0] par_wdata_in,
    input  wire logic               par_wr_in,
    input  wire logic               par_rd_in,
    output logic             [31:0] par_rdata_out,
    output logic                    par_rvalid_out,
    output logic                    par_err_out,
    // Digital input and pulse pins
    input  wire sfc_din_t           din_in,
    // Drive state
    input  wire logic               numerator_select_assigned_in,
    input  wire logic               speed_mode_in,
    input  wire logic               position_pulse_mode_in,
    input  wire logic               analog_source_in,
    input  wire logic signed [15:0] speed_cmd_in,
    input  wire logic        [15:0] clamp_speed_threshold_in,
    input  wire logic        [31:0] default_numerator_in,
    input  wire logic        [31:0] gear_numerator_two_in,
    input  wire sfc_fault_t         fault_raw_in,
    // Results
    output logic             [31:0] active_numerator_out,
    output logic signed      [15:0] speed_cmd_out,
    output logic                    position_lock_out,
    output logic                    zero_clamp_active_out,
    output logic                    pulse_fwd_out,
    output logic                    pulse_rev_out,
    output logic                    pulse_blocked_out,
    output sfc_fault_t              fault_out
);
    // Synchronised pins
    sfc_din_t din_s;

    sfc_pin_sync #(
        .W ($bits(sfc_din_t))
    ) u_din_sync (
        .clk_in   (clk_in),
        .srst_in  (srst_in),
        .pin_in   (din_in),
        .sync_out (din_s)
    );

    // Parameter registers
    logic [31:0] gear3_reg;
    logic [31:0] gear3_next;
    logic [31:0] gear4_reg;
    logic [31:0] gear4_next;
    logic [15:0] sfw1_reg;
    logic [15:0] sfw1_next;
    logic [15:0] sfw2_reg;
    logic [15:0] sfw2_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        rvalid_reg;
    logic        rvalid_next;
    logic        err_reg;
    logic        err_next;
    logic        gear_ok;
    logic        hit;

    // Out-of-range numerators are dropped so the gear never becomes zero
    always_comb begin
        gear3_next  = gear3_reg;
        gear4_next  = gear4_reg;
        sfw1_next   = sfw1_reg;
        sfw2_next   = sfw2_reg;
        rdata_next  = '0;
        rvalid_next = par_rd_in;
        gear_ok     = (par_wdata_in >= GEAR_MIN) && (par_wdata_in <= GEAR_MAX);
        hit         = 1'b1;
        case (par_addr_in)
            ADDR_GEAR3: begin
                rdata_next = gear3_reg;
                if (par_wr_in && gear_ok) begin
                    gear3_next = par_wdata_in;
                end
            end
            ADDR_GEAR4: begin
                rdata_next = gear4_reg;
                if (par_wr_in && gear_ok) begin
                    gear4_next = par_wdata_in;
                end
            end
            ADDR_RSVD_A, ADDR_RSVD_B: begin
                rdata_next = '0;
            end
            ADDR_SFW1: begin
                rdata_next = {16'h0000, sfw1_reg};
                if (par_wr_in) begin
                    // Reserved bits are stored as written; software keeps them zero
                    sfw1_next = par_wdata_in[15:0]; // [RULE_02] [RULE_15]
                end
            end
            ADDR_SFW2: begin
                rdata_next = {16'h0000, sfw2_reg};
                if (par_wr_in) begin
                    sfw2_next = par_wdata_in[15:0];
                end
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        err_next = (par_rd_in || par_wr_in) && !hit;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            gear3_reg  <= GEAR3_RST;
            gear4_reg  <= GEAR4_RST;
            sfw1_reg   <= SFW1_RST;
            sfw2_reg   <= SFW2_RST;
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
            err_reg    <= 1'b0;
        end else begin
            gear3_reg  <= gear3_next;
            gear4_reg  <= gear4_next;
            sfw1_reg   <= sfw1_next;
            sfw2_reg   <= sfw2_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            err_reg    <= err_next;
        end
    end

    // Ramp tick divider
    logic [15:0] tick_cnt_reg;
    logic [15:0] tick_cnt_next;
    logic        tick;

    always_comb begin
        tick          = (tick_cnt_reg == 16'(RAMP_TICK_CYC - 1));
        tick_cnt_next = tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    // Zero clamp and speed command path
    logic [16:0]        cmd_mag;
    logic               clamp;
    logic               ramp_force;
    logic signed [15:0] ramp_target;

    always_comb begin
        cmd_mag = speed_cmd_in[15] ? 17'h00000 - 17'(speed_cmd_in) : 17'(speed_cmd_in);
        clamp   = speed_mode_in && din_s.zero_clamp_input
                  && (cmd_mag < {1'b0, clamp_speed_threshold_in}); // [RULE_06]
        ramp_target = speed_cmd_in;
        ramp_force  = 1'b1;
        if (sfw1_reg[BIT_ZC_MODE]) begin
            if (clamp) begin
                ramp_target = '0; // [RULE_08] [RULE_09]
            end
            // Only the analog source runs through the ramp
            ramp_force = !analog_source_in; // [RULE_08] [RULE_09]
        end
    end

    sfc_speed_ramp u_ramp (
        .clk_in    (clk_in),
        .srst_in   (srst_in),
        .tick_in   (tick),
        .force_in  (ramp_force),
        .target_in (ramp_target),
        .speed_out (speed_cmd_out)
    );

    // Gear select, pulse gating and fault gating
    logic [31:0] num_reg;
    logic [31:0] num_next;
    logic        lock_reg;
    logic        lock_next;
    logic        clamp_reg;
    logic        pfwd_reg;
    logic        pfwd_next;
    logic        prev_reg;
    logic        prev_next;
    logic        prev_pulse_reg;
    logic        prev_pulse_next;
    logic        pblk_reg;
    logic        pblk_next;
    sfc_fault_t  fault_reg;
    sfc_fault_t  fault_next;
    logic        pulse_evt;
    logic        fwd_block;
    logic        rev_block;

    always_comb begin
        num_next = default_numerator_in;
        if (numerator_select_assigned_in) begin // [RULE_01]
            case ({din_s.numerator_select_high, din_s.numerator_select_low})
                SEL_DEFAULT: num_next = default_numerator_in;
                SEL_TWO:     num_next = gear_numerator_two_in;
                SEL_THREE:   num_next = gear3_reg;
                default:     num_next = gear4_reg;
            endcase
        end
        lock_next = !sfw1_reg[BIT_ZC_MODE] && clamp; // [RULE_07]

        // Limits only gate pulses when the inhibit bit is set
        fwd_block = sfw1_reg[BIT_LIM_INH] && din_s.forward_limit_input; // [RULE_10] [RULE_11] [RULE_12]
        rev_block = sfw1_reg[BIT_LIM_INH] && din_s.reverse_limit_input; // [RULE_10] [RULE_11] [RULE_12]
        pulse_evt = position_pulse_mode_in && din_s.pulse && !prev_pulse_reg;
        pfwd_next       = pulse_evt && din_s.dir_fwd && !fwd_block; // [RULE_11]
        prev_next       = pulse_evt && !din_s.dir_fwd && !rev_block; // [RULE_11]
        pblk_next       = pulse_evt && (din_s.dir_fwd ? fwd_block : rev_block);
        prev_pulse_next = din_s.pulse;

        fault_next.abnormal_pulse       = fault_raw_in.abnormal_pulse && !sfw1_reg[BIT_ABN_DIS]; // [RULE_03]
        fault_next.wiring_error         = fault_raw_in.wiring_error && sfw1_reg[BIT_WIRE_ERR]; // [RULE_04]
        fault_next.wiring_cutoff        = fault_raw_in.wiring_cutoff && sfw1_reg[BIT_WIRE_CUT]; // [RULE_05]
        fault_next.phase_loss_fault     = fault_raw_in.phase_loss_fault && !sfw1_reg[BIT_PHL_DIS]; // [RULE_13]
        fault_next.encoder_output_fault = fault_raw_in.encoder_output_fault
                                          && !sfw1_reg[BIT_ENC_DIS]; // [RULE_14]
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            num_reg        <= '0;
            lock_reg       <= 1'b0;
            clamp_reg      <= 1'b0;
            pfwd_reg       <= 1'b0;
            prev_reg       <= 1'b0;
            pblk_reg       <= 1'b0;
            prev_pulse_reg <= 1'b0;
            fault_reg      <= '0;
        end else begin
            num_reg        <= num_next;
            lock_reg       <= lock_next;
            clamp_reg      <= clamp;
            pfwd_reg       <= pfwd_next;
            prev_reg       <= prev_next;
            pblk_reg       <= pblk_next;
            prev_pulse_reg <= prev_pulse_next;
            fault_reg      <= fault_next;
        end
    end

    assign par_rdata_out         = rdata_reg;
    assign par_rvalid_out        = rvalid_reg;
    assign par_err_out           = err_reg;
    assign active_numerator_out  = num_reg;
    assign position_lock_out     = lock_reg;
    assign zero_clamp_active_out = clamp_reg;
    assign pulse_fwd_out         = pfwd_reg;
    assign pulse_rev_out         = prev_reg;
    assign pulse_blocked_out     = pblk_reg;
    assign fault_out             = fault_reg;

endmodule : sfc_special_function

// *** test/sfc_host_model.sv ***
`timescale 1ns/1ps
module sfc_host_model (
    // Clock
    input  wire logic clk_in,
    // Request from the bench
    input  wire logic send_in,
    input  wire logic fwd_in,
    // Pins toward the drive
    output logic      pulse_out,
    output logic      dir_out,
    output logic      busy_out
);
    initial begin
        pulse_out = 1'b0;
        dir_out   = 1'b0;
        busy_out  = 1'b0;
    end
    // Direction settles three cycles ahead of the edge; the drive filters only one-cycle pulses
    always @(posedge clk_in) begin
        if (send_in && !busy_out) begin
            busy_out <= 1'b1;
            dir_out  <= fwd_in;
            repeat (3) @(posedge clk_in);
            pulse_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            pulse_out <= 1'b0;
            repeat (4) @(posedge clk_in);
            busy_out <= 1'b0;
        end
    end
endmodule : sfc_host_model

// *** test/sfc_special_function_sva.sv ***
`timescale 1ns/1ps
module sfc_special_function_sva import sfc_pkg::*; (
    // Clock and reset
    input wire logic        clk_in,
    input wire logic        srst_in,
    // Parameter port
    input wire logic [15:0] par_addr_in,
    input wire logic [31:0] par_wdata_in,
    input wire logic        par_wr_in,
    // Pins and drive state
    input wire sfc_din_t    din_in,
    input wire logic        numerator_select_assigned_in,
    input wire logic        speed_mode_in,
    input wire logic        analog_source_in,
    input wire logic [31:0] default_numerator_in,
    input wire sfc_fault_t  fault_raw_in,
    // Results
    input wire logic [31:0] active_numerator_out,
    input wire logic signed [15:0] speed_cmd_out,
    input wire logic        zero_clamp_active_out,
    input wire logic        pulse_fwd_out,
    input wire logic        pulse_rev_out,
    input wire logic        pulse_blocked_out,
    input wire sfc_fault_t  fault_out
);
    logic [15:0] sfw_reg;
    logic [15:0] sfw_next;
    sfc_fault_t  exp_fault;
    // Shadow of word one, since the stored copy is not visible at the ports
    always_comb begin
        sfw_next = sfw_reg;
        if (par_wr_in && par_addr_in == ADDR_SFW1) begin
            sfw_next = par_wdata_in[15:0];
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sfw_reg <= SFW1_RST;
        end else begin
            sfw_reg <= sfw_next;
        end
    end
    assign exp_fault = fault_raw_in & {~sfw_reg[BIT_ABN_DIS], sfw_reg[BIT_WIRE_ERR], sfw_reg[BIT_WIRE_CUT],
                                       ~sfw_reg[BIT_PHL_DIS], ~sfw_reg[BIT_ENC_DIS]};
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    property p_abn; !srst_in |=> fault_out.abnormal_pulse == $past(exp_fault.abnormal_pulse); endproperty
    a_abn: assert property (p_abn) else $error("abnormal pulse gate wrong");
    property p_wire; !srst_in |=> fault_out.wiring_error == $past(exp_fault.wiring_error); endproperty
    a_wire: assert property (p_wire) else $error("wiring error gate wrong");
    property p_cut; !srst_in |=> fault_out.wiring_cutoff == $past(exp_fault.wiring_cutoff); endproperty
    a_cut: assert property (p_cut) else $error("wiring cutoff gate wrong");
    property p_phl; !srst_in |=> fault_out.phase_loss_fault == $past(exp_fault.phase_loss_fault); endproperty
    a_phl: assert property (p_phl) else $error("phase loss gate wrong");
    property p_enc; !srst_in |=> fault_out.encoder_output_fault == $past(exp_fault.encoder_output_fault); endproperty
    a_enc: assert property (p_enc) else $error("encoder fault gate wrong");
    property p_clmp; !speed_mode_in |=> !zero_clamp_active_out; endproperty
    a_clmp: assert property (p_clmp) else $error("clamp outside speed mode");
    property p_zero; (sfw_reg[BIT_ZC_MODE] && !analog_source_in && zero_clamp_active_out) [*4] |->
        speed_cmd_out == 16'sh0000; endproperty
    a_zero: assert property (p_zero) else $error("internal clamp not forced to zero");
    property p_num; !srst_in && !numerator_select_assigned_in |=>
        active_numerator_out == $past(default_numerator_in); endproperty
    a_num: assert property (p_num) else $error("default numerator not used");
    property p_noinh; !sfw_reg[BIT_LIM_INH] [*8] |-> !pulse_blocked_out; endproperty
    a_noinh: assert property (p_noinh) else $error("pulse blocked with inhibit off");
    property p_both; (sfw_reg[BIT_LIM_INH] && din_in.forward_limit_input && din_in.reverse_limit_input) [*8]
        |-> !(pulse_fwd_out || pulse_rev_out); endproperty
    a_both: assert property (p_both) else $error("pulse passed at both limits");
    c_blk: cover property (pulse_blocked_out);
    c_rev: cover property (pulse_rev_out);
    c_clmp: cover property (zero_clamp_active_out);
endmodule : sfc_special_function_sva

bind sfc_special_function sfc_special_function_sva sfc_special_function_sva_inst (.clk_in, .srst_in,
    .par_addr_in, .par_wdata_in, .par_wr_in, .din_in, .numerator_select_assigned_in, .speed_mode_in,
    .analog_source_in, .default_numerator_in, .fault_raw_in, .active_numerator_out, .speed_cmd_out,
    .zero_clamp_active_out, .pulse_fwd_out, .pulse_rev_out, .pulse_blocked_out, .fault_out);

// *** test/sfc_special_function_tb.sv ***
`timescale 1ns/1ps
module sfc_special_function_tb import sfc_pkg::*; ;
    logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, assigned = 1'b1, smode = 1'b0, pmode = 1'b1;
    logic analog = 1'b0, send = 1'b0, dir = 1'b0, zc = 1'b0, rl = 1'b0, fl = 1'b0, nsh = 1'b0, nsl = 1'b0;
    logic [15:0] addr = 16'h0000, thr = 16'h0100;
    logic [31:0] wdata = 32'h0000_0000, rdata, num;
    logic signed [15:0] cmd = 16'sh0050, spd;
    logic rvalid, err, lock, clamp, pf, pr, pb, hp, hd, busy;
    logic [3:0] cf = 4'h0, cr = 4'h0, cb = 4'h0;
    logic [31:0] nums [4] = '{32'h0000_0AAA, 32'h0000_0BBB, 32'h0000_1234, 32'h0000_0010};
    logic [15:0] words [3] = '{16'h0000, 16'h3340, 16'h0100};
    logic [4:0] faults [3] = '{5'h13, 5'h0C, 5'h1B};
    // Entries: inhibit, forward limit, reverse limit, direction, expected {fwd, rev, blocked}
    logic [6:0] pc [7] = '{7'h3C, 7'h69, 7'h62, 7'h51, 7'h79, 7'h71, 7'h4C};
    sfc_fault_t raw = 5'h1F;
    sfc_fault_t fault;
    sfc_din_t din;
    int mismatches = 0, num_checks = 0, cyc = 0;
    assign din = {zc, rl, fl, nsh, nsl, hp, hd};
    always #10 clk = ~clk;
    sfc_special_function sfc_special_function_inst (.clk_in(clk), .srst_in(srst), .par_addr_in(addr),
        .par_wdata_in(wdata), .par_wr_in(wr), .par_rd_in(rd), .par_rdata_out(rdata), .par_rvalid_out(rvalid),
        .par_err_out(err), .din_in(din), .numerator_select_assigned_in(assigned), .speed_mode_in(smode),
        .position_pulse_mode_in(pmode), .analog_source_in(analog), .speed_cmd_in(cmd),
        .clamp_speed_threshold_in(thr), .default_numerator_in(nums[0]), .gear_numerator_two_in(nums[1]),
        .fault_raw_in(raw), .active_numerator_out(num), .speed_cmd_out(spd), .position_lock_out(lock),
        .zero_clamp_active_out(clamp), .pulse_fwd_out(pf), .pulse_rev_out(pr), .pulse_blocked_out(pb),
        .fault_out(fault));
    sfc_host_model sfc_host_model_inst (.clk_in(clk), .send_in(send), .fwd_in(dir), .pulse_out(hp),
        .dir_out(hd), .busy_out(busy));
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    // Cycle ceiling well above the longest path through the ramp scenarios
    always @(posedge clk) begin
        cyc <= cyc + 1;
        // Counting waits for reset so unknown outputs cannot poison the totals
        if (!srst) begin
            cf <= cf + {3'h0, pf};
            cr <= cr + {3'h0, pr};
            cb <= cb + {3'h0, pb};
        end
        if (cyc == 30000) begin
            mismatches++;
            test_done();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wrw(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrw
    task rdw(input logic [15:0] a, input logic [31:0] e, input logic ee);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk({rvalid, err}, {1'b1, ee});
        chk(rdata, e);
    endtask : rdw
    // Counts accepted and inhibited edges over one complete host pulse
    task pulse(input logic f, input logic [2:0] e);
        logic [11:0] s;
        s = {cf, cr, cb};
        @(posedge clk);
        dir <= f;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        for (int i = 0; i < 40 && (busy === 1'b1 || i < 2); i++) @(posedge clk);
        repeat (12) @(posedge clk);
        chk({cf, cr, cb}, s + {3'h0, e[2], 3'h0, e[1], 3'h0, e[0]});
    endtask : pulse
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rdw(ADDR_GEAR3, 32'h0000_0010, 1'b0);
        rdw(ADDR_GEAR4, 32'h0000_0010, 1'b0);
        rdw(ADDR_SFW1, 32'h0, 1'b0);
        rdw(ADDR_SFW2, 32'h0, 1'b0);
        wrw(ADDR_RSVD_A, 32'h0000_5555);
        rdw(ADDR_RSVD_A, 32'h0, 1'b0);
        rdw(16'h0290, 32'h0, 1'b1);
        wrw(ADDR_GEAR3, 32'h0000_1234);
        wrw(ADDR_GEAR4, 32'h0000_0000);
        wrw(ADDR_GEAR4, 32'h0400_0000);
        wrw(ADDR_SFW2, 32'h1234_A5C3);
        rdw(ADDR_SFW2, 32'h0000_A5C3, 1'b0);
        rdw(ADDR_GEAR3, 32'h0000_1234, 1'b0);
        rdw(ADDR_GEAR4, 32'h0000_0010, 1'b0);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            nsh <= k[1];
            nsl <= k[0];
            repeat (8) @(posedge clk);
            chk(num, nums[k]);
        end
        assigned <= 1'b0;
        repeat (3) @(posedge clk);
        chk(num, nums[0]);
        for (int k = 0; k < 3; k++) begin
            wrw(ADDR_SFW1, {16'h0, words[k]});
            repeat (2) @(posedge clk);
            #1 chk(32'(fault), 32'(faults[k]));
        end
        @(posedge clk);
        raw <= 5'h00;
        repeat (2) @(posedge clk);
        #1 chk(32'(fault), 32'h0);
        for (int k = 0; k < 7; k++) begin
            wrw(ADDR_SFW1, {20'h0, pc[k][6], 11'h0});
            @(posedge clk);
            fl <= pc[k][5];
            rl <= pc[k][4];
            repeat (10) @(posedge clk);
            pulse(pc[k][3], pc[k][2:0]);
        end
        pmode <= 1'b0;
        pulse(1'b1, 3'h0);
        wrw(ADDR_SFW1, 32'h0);
        @(posedge clk);
        smode <= 1'b1;
        zc <= 1'b1;
        repeat (8) @(posedge clk);
        #1 chk({clamp, lock, spd}, {2'b11, 16'h0050});
        cmd <= 16'sh0100;
        repeat (8) @(posedge clk);
        chk(clamp, 1'b0);
        cmd <= 16'sh0050;
        smode <= 1'b0;
        repeat (8) @(posedge clk);
        chk(clamp, 1'b0);
        smode <= 1'b1;
        wrw(ADDR_SFW1, 32'h0000_0400);
        repeat (8) @(posedge clk);
        chk({clamp, lock, spd}, {2'b10, 16'h0000});
        zc <= 1'b0;
        repeat (8) @(posedge clk);
        chk(spd, 16'h0050);
        analog <= 1'b1;
        zc <= 1'b1;
        repeat (10) @(posedge clk);
        chk(spd[15:6], 10'h001);
        repeat (3000) @(posedge clk);
        chk(spd, 16'h0000);
        zc <= 1'b0;
        repeat (3000) @(posedge clk);
        chk(spd, 16'h0050);
        test_done();
    end
endmodule : sfc_special_function_tb
